// ===== hw/acd_map.vh
// Constants for the arithmetic and compare decoder
`ifndef ACD_MAP_VH
`define ACD_MAP_VH

// Instruction field positions
`define ACD_OP_HI       15
`define ACD_OP_LO       12
`define ACD_VAR_HI      11
`define ACD_VAR_LO      10
`define ACD_ROW_HI      9
`define ACD_ROW_LO      8
`define ACD_COL_HI      7
`define ACD_COL_LO      4
`define ACD_LOW_HI      3
`define ACD_LOW_LO      0

// Opcode high nibbles
`define ACD_OP_CMPA     4'h0
`define ACD_OP_CMPB     4'h1
`define ACD_OP_ADD_RM   4'h4
`define ACD_OP_ADD_MI   4'h5
`define ACD_OP_SUB_RM   4'h6
`define ACD_OP_SUB_MI   4'h7

// Variant field codes
`define ACD_VAR_PLAIN   2'h0
`define ACD_VAR_SKIP    2'h1
`define ACD_VAR_CY      2'h2
`define ACD_VAR_CY_SKIP 2'h3

// Reset values
`define ACD_RST_NIB     4'h0
`define ACD_RST_ADDR    6'h00
`define ACD_RST_FLAG    1'b0

`endif

// ===== hw/acd_alu.v
// Four-bit adder and subtractor with carry or borrow
`timescale 1ns/1ns
`default_nettype none

module acd_alu (
	input  wire [3:0] i_a,
	input  wire [3:0] i_b,
	input  wire       i_sub,
	input  wire       i_use_flag,
	input  wire       i_flag,
	output wire [3:0] o_res,
	output wire       o_flag
);

	wire [3:0] b_eff;
	wire       cin;
	wire [4:0] sum;

	// Subtraction as a + ~b + ~borrow
	assign b_eff = i_sub ? ~i_b : i_b;
	assign cin   = i_sub ? ~(i_use_flag & i_flag) : (i_use_flag & i_flag);
	assign sum   = {1'b0, i_a} + {1'b0, b_eff} + {4'h0, cin};
	assign o_res = sum[3:0];
	assign o_flag = i_sub ? ~sum[4] : sum[4];

endmodule

`default_nettype wire

// ===== hw/acd_decoder.v
// Decode and execute unit for arithmetic and compare instructions
//
// Behaviour
// - Row address of the memory operand comes from bits 9 to 8.
// - Column address comes from bits 7 to 4; row and column pick memory.
// - Immediate instructions take a 4-bit immediate from bits 3 to 0.
// - Register instructions pick one of sixteen registers by bits 3:0.
// - Nibble 0100 adds memory to register; plain, skip, carry, both.
// - Nibble 0101 adds immediate to memory into memory; four variants.
// - 0110 subtracts memory from register; plain, skip, borrow, both.
// - Nibble 0111 subtracts immediate from memory into memory; 4 variants.
// - 0001 variant 00 skips when register equals memory; nothing modified.
// - 0001 variant 01 skips when memory equals immediate.
// - 0000 variant 01 skips when memory differs from immediate.
// - 0000 variant 11 skips when register minus memory gives no borrow.
// - 0001 variant 11 skips when memory minus immediate gives no borrow.
`timescale 1ns/1ns
`default_nettype none
`include "acd_map.vh"

module acd_decoder (
	input  wire        i_sys_clk,
	input  wire        i_arst_n,
	input  wire [15:0] i_instr,
	input  wire        i_instr_vld,
	output reg         o_instr_rdy,
	output reg  [5:0]  o_mem_addr,
	output reg         o_mem_rd,
	input  wire [3:0]  i_mem_rdata,
	output reg         o_mem_wr,
	output reg  [3:0]  o_mem_wdata,
	output reg         o_skip,
	output reg         o_done,
	output reg         o_carry
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WAIT = 2'h1;
	localparam [1:0] ST_EXEC = 2'h2;

	////////////////////////////////////////////////////////////////
	// State

	reg  [1:0]  state_r;
	reg  [15:0] instr_r;
	reg         skip_pend_r;
	reg  [3:0]  greg_r [0:15];

	wire        take;
	wire [3:0]  op;
	wire [1:0]  vsel;
	wire [5:0]  addr_in;
	wire [3:0]  low;
	wire [3:0]  reg_val;
	integer     k;

	assign take    = i_instr_vld & o_instr_rdy;
	assign op      = instr_r[`ACD_OP_HI:`ACD_OP_LO];
	assign vsel    = instr_r[`ACD_VAR_HI:`ACD_VAR_LO];
	assign addr_in = {i_instr[`ACD_ROW_HI:`ACD_ROW_LO],
	                  i_instr[`ACD_COL_HI:`ACD_COL_LO]};
	assign low     = instr_r[`ACD_LOW_HI:`ACD_LOW_LO];
	assign reg_val = greg_r[low];

	////////////////////////////////////////////////////////////////
	// Decode

	function is_supported;
		input [3:0] f_op;
		input [1:0] f_var;
		begin
			if (f_op[3:2] == 2'b01) begin
				is_supported = 1'b1;
			end else if (f_op == `ACD_OP_CMPB) begin
				is_supported = (f_var != `ACD_VAR_CY);
			end else if (f_op == `ACD_OP_CMPA) begin
				is_supported = (f_var == `ACD_VAR_SKIP) ||
				               (f_var == `ACD_VAR_CY_SKIP);
			end else begin
				is_supported = 1'b0;
			end
		end
	endfunction

	reg  [3:0] alu_a;
	reg  [3:0] alu_b;
	reg        alu_sub;
	reg        alu_use;
	reg        skip_nxt;
	reg        wr_reg_nxt;
	reg        wr_mem_nxt;
	reg        flag_upd_nxt;
	wire [3:0] alu_res;
	wire       alu_flag;

	acd_alu u_alu (
		.i_a        (alu_a),
		.i_b        (alu_b),
		.i_sub      (alu_sub),
		.i_use_flag (alu_use),
		.i_flag     (o_carry),
		.o_res      (alu_res),
		.o_flag     (alu_flag)
	);

	always @* begin
		alu_a        = reg_val;
		alu_b        = i_mem_rdata;
		alu_sub      = 1'b1;
		alu_use      = 1'b0;
		skip_nxt     = 1'b0;
		wr_reg_nxt   = 1'b0;
		wr_mem_nxt   = 1'b0;
		flag_upd_nxt = 1'b0;
		case (op)
		`ACD_OP_ADD_RM: begin
			alu_sub      = 1'b0;
			alu_use      = vsel[1];
			skip_nxt     = vsel[0] & alu_flag;
			wr_reg_nxt   = 1'b1;
			flag_upd_nxt = 1'b1;
		end
		`ACD_OP_ADD_MI: begin
			alu_a        = i_mem_rdata;
			alu_b        = low;
			alu_sub      = 1'b0;
			alu_use      = vsel[1];
			skip_nxt     = vsel[0] & alu_flag;
			wr_mem_nxt   = 1'b1;
			flag_upd_nxt = 1'b1;
		end
		`ACD_OP_SUB_RM: begin
			alu_use      = vsel[1];
			skip_nxt     = vsel[0] & alu_flag;
			wr_reg_nxt   = 1'b1;
			flag_upd_nxt = 1'b1;
		end
		`ACD_OP_SUB_MI: begin
			alu_a        = i_mem_rdata;
			alu_b        = low;
			alu_use      = vsel[1];
			skip_nxt     = vsel[0] & alu_flag;
			wr_mem_nxt   = 1'b1;
			flag_upd_nxt = 1'b1;
		end
		`ACD_OP_CMPB: begin
			if (vsel == `ACD_VAR_PLAIN) begin
				skip_nxt = (reg_val == i_mem_rdata);
			end else if (vsel == `ACD_VAR_SKIP) begin
				skip_nxt = (i_mem_rdata == low);
			end else if (vsel == `ACD_VAR_CY_SKIP) begin
				alu_a    = i_mem_rdata;
				alu_b    = low;
				skip_nxt = ~alu_flag;
			end
		end
		`ACD_OP_CMPA: begin
			if (vsel == `ACD_VAR_SKIP) begin
				skip_nxt = (i_mem_rdata != low);
			end else if (vsel == `ACD_VAR_CY_SKIP) begin
				skip_nxt = ~alu_flag;
			end
		end
		default: begin
			skip_nxt = 1'b0;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Sequencing

	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r     <= ST_IDLE;
			instr_r     <= 16'h0000;
			skip_pend_r <= 1'b0;
			o_instr_rdy <= 1'b0;
			o_mem_addr  <= `ACD_RST_ADDR;
			o_mem_rd    <= 1'b0;
			o_mem_wr    <= 1'b0;
			o_mem_wdata <= `ACD_RST_NIB;
			o_skip      <= 1'b0;
			o_done      <= 1'b0;
			o_carry     <= `ACD_RST_FLAG;
			for (k = 0; k < 16; k = k + 1) begin
				greg_r[k] <= `ACD_RST_NIB;
			end
		end else begin
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_skip   <= 1'b0;
			o_done   <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				o_instr_rdy <= 1'b1;
				if (take) begin
					if (skip_pend_r ||
					    !is_supported(i_instr[`ACD_OP_HI:`ACD_OP_LO],
					                  i_instr[`ACD_VAR_HI:`ACD_VAR_LO])) begin
						skip_pend_r <= 1'b0;
						o_done      <= 1'b1;
					end else begin
						instr_r     <= i_instr;
						o_mem_addr  <= addr_in;
						o_mem_rd    <= 1'b1;
						o_instr_rdy <= 1'b0;
						state_r     <= ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				state_r <= ST_EXEC;
			end
			ST_EXEC: begin
				if (wr_reg_nxt) begin
					greg_r[low] <= alu_res;
				end
				o_mem_wr    <= wr_mem_nxt;
				o_mem_wdata <= alu_res;
				if (flag_upd_nxt) begin
					o_carry <= alu_flag;
				end
				o_skip      <= skip_nxt;
				skip_pend_r <= skip_nxt;
				o_done      <= 1'b1;
				o_instr_rdy <= 1'b1;
				state_r     <= ST_IDLE;
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== sim/acd_decoder_properties.sv
// Port assertions for the decoder
`timescale 1ns/1ns
`default_nettype none
module acd_decoder_props (
	input wire logic		i_sys_clk,
	input wire logic		i_arst_n,
	input wire logic [15:0]	i_instr,
	input wire logic		i_instr_vld,
	input wire logic		o_instr_rdy,
	input wire logic [5:0]	o_mem_addr,
	input wire logic		o_mem_rd,
	input wire logic [3:0]	i_mem_rdata,
	input wire logic		o_mem_wr,
	input wire logic [3:0]	o_mem_wdata,
	input wire logic		o_skip,
	input wire logic		o_done,
	input wire logic		o_carry
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	logic	pend_r;
	wire	take = i_instr_vld && o_instr_rdy;
	wire	sup = !i_instr[15] && (i_instr[14] || (!i_instr[13]
		&& (i_instr[10] || (i_instr[12] && !i_instr[11]))));
	wire	go = take && sup && !pend_r && !o_skip;
	// Skip waiting for the next taken word
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
		if (!i_arst_n)
			pend_r <= 1'b0;
		else
			pend_r <= !take && (pend_r || o_skip);
	property p_rd; go |=> o_mem_rd && o_mem_addr == $past(i_instr[9:4]); endproperty
	a_rd: assert property (p_rd) else $error("addr");
	property p_drop; take && !go |=> o_done && !o_mem_rd; endproperty
	a_drop: assert property (p_drop) else $error("drop");
	property p_busy;
		go |=> !o_instr_rdy [*2] ##1 o_done && o_instr_rdy;
	endproperty
	a_busy: assert property (p_busy) else $error("busy");
	property p_wr; go && i_instr[14] && i_instr[12] |-> ##3 o_mem_wr; endproperty
	a_wr: assert property (p_wr) else $error("wr");
	property p_nowr; go && !(i_instr[14] && i_instr[12]) |-> ##3 !o_mem_wr; endproperty
	a_nowr: assert property (p_nowr) else $error("nowr");
	property p_sk; o_skip |-> o_done; endproperty
	a_sk: assert property (p_sk) else $error("skip");
	property p_eq;
		go && i_instr[15:10] == 6'h05
		|-> ##3 o_skip == ($past(i_mem_rdata) == $past(i_instr[3:0], 3));
	endproperty
	a_eq: assert property (p_eq) else $error("eq");
	property p_ai;
		go && i_instr[15:10] == 6'h14
		|-> ##3 o_mem_wdata == $past(i_mem_rdata) + $past(i_instr[3:0], 3);
	endproperty
	a_ai: assert property (p_ai) else $error("sum");
	c_go: cover property (go);
	c_drop: cover property (take && !go);
	c_skip: cover property (o_skip);
endmodule
bind acd_decoder acd_decoder_props u_props (.*);
`default_nettype wire

// ===== sim/acd_mem_model.sv
// Data memory model behind the decoder
`timescale 1ns/1ns
`default_nettype none
module acd_mem_model (
	input wire logic		i_clk,
	input wire logic		i_rst_n,
	input wire logic [5:0]	i_addr,
	input wire logic		i_rd,
	input wire logic		i_wr,
	input wire logic [3:0]	i_wdata,
	output var logic [3:0]	o_rdata
);
	logic [3:0]	mem [0:63];
	// Data valid one cycle after a read, toggling otherwise
	always @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
			o_rdata <= 4'h0;
		else
			o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
	always @(posedge i_clk)
		if (i_wr)
			mem[i_addr] <= i_wdata;
endmodule
`default_nettype wire

// ===== sim/acd_decoder_tb_top.sv
// Self-checking bench for the decoder
`timescale 1ns/1ns
`default_nettype none
module acd_decoder_tb_top;
	logic		i_sys_clk = 1'b0, i_arst_n = 1'b0, i_instr_vld = 1'b0;
	logic [15:0]	i_instr = 16'h0000;
	logic [3:0]	i_mem_rdata, o_mem_wdata;
	logic [5:0]	o_mem_addr;
	logic		o_instr_rdy, o_mem_rd, o_mem_wr, o_skip, o_done, o_carry;
	int		n_fail = 0, n_compared = 0, n;
	acd_decoder u_dut (.*);
	acd_mem_model u_mem (.i_clk(i_sys_clk), .i_rst_n(i_arst_n),
		.i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
		.i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	initial forever #4 i_sys_clk = ~i_sys_clk;
	task chk(input logic [3:0] g, input logic [3:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One instruction through the handshake, skip judged at done
	task run(input logic [15:0] w, input logic s);
		@(posedge i_sys_clk);
		i_instr <= w;
		i_instr_vld <= 1'b1;
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while (o_instr_rdy !== 1'b1 && n < 50);
		chk(o_instr_rdy, 4'h1);
		@(posedge i_sys_clk);
		i_instr_vld <= 1'b0;
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while (o_done !== 1'b1 && n < 50);
		chk(o_done, 4'h1);
		chk(o_skip, s);
		@(negedge i_sys_clk);
	endtask
	task end_sim;
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task s_imm;
		u_mem.mem[6'h25] = 4'he;
		run(16'h5253, 1'b0);
		run(16'h5e50, 1'b0);
		run(16'h565f, 1'b1);
		run(16'h5253, 1'b0);
		chk(u_mem.mem[6'h25], 4'h1);
	endtask
	task s_reg;
		u_mem.mem[6'h07] = 4'h7;
		u_mem.mem[6'h08] = 4'h9;
		run(16'h4075, 1'b0);
		run(16'h1075, 1'b1);
		run(16'h6085, 1'b0);
		run(16'h6085, 1'b0);
		chk(o_carry, 4'h1);
		run(16'h0c75, 1'b1);
	endtask
	task s_cmp;
		u_mem.mem[6'h3f] = 4'h3;
		run(16'h0800, 1'b0);
		run(16'h17f3, 1'b1);
		run(16'h07f3, 1'b0);
		run(16'h07f3, 1'b0);
		run(16'h1ff4, 1'b0);
		run(16'h77f4, 1'b1);
		chk(u_mem.mem[6'h3f], 4'hf);
		run(16'h3000, 1'b0);
		run(16'h0800, 1'b0);
		run(16'h7ff0, 1'b0);
		chk(u_mem.mem[6'h3f], 4'he);
	endtask
	initial begin
		#20000;
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (3) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		s_imm;
		s_reg;
		s_cmp;
		end_sim;
	end
endmodule
`default_nettype wire
